//--- hdl/fsu_top.sv
// Purpose: fifo serial unit, asynchronous mode, with apb register access
// Assumes: pclk 100 MHz; remote device drives rxd and cts_n from its own clock
// Notes: sync mode only selects the sclk pin role and keeps the internal tick
// Overview of operation
// - sync bit 0: async frames, 8 or 7 data bits, parity option, 1/2 stops
// - async select 00: internal clock, sclk pin follows port direction and value bits
// - async select 01 drives 16x clock out; 10 takes 16x clock in; 11 prohibited
// - sync mode: high select 0 drives sclk pin constant high; 10 inputs; 11 prohibited
// - idle line is mark high; falling line starts a received character
// - frame order: low start, data lsb first, optional parity, high stops
// - receiver syncs to start edge, samples each bit on eighth 16x pulse
// - independent transmitter and receiver, each with 16-byte fifo
// - clearing transmit enable resets shifter; flags and fifos are kept
// - transmit enable cleared mid-frame puts line at mark at once
// - fifo write starts sending; frames go back to back until fifo empty
// - tx fifo count at or below trigger sets low flag; interrupt if enabled
// - parity bit even or odd when enabled, then one or two stop ones
// - at stop time load next byte if waiting, else set end flag, hold mark
// - modem control: cts high halts after frame, cts low lets next start
// - store only if stop is one, fifo has room, overrun and break clear
// - parity or framing errors do not suspend reception
// - rx irq on full or ready; the ready flag is never set, so only full raises it; error and break irqs with either enable
// - modem control: rts low while reception possible, high when fifo full
// - char completing into full fifo sets overrun, is lost; clear by read-then-0
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fsu_cfg.svh"
module fsu_top
  import fsu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        cts_n,
  output logic             rts_n,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  output logic             tx_fifo_irq,
  output logic             rx_data_irq,
  output logic             rx_error_irq,
  output logic             break_irq
);
  localparam int DEPTH = `FSU_FIFO_DEPTH;

  // registers
  logic [7:0]  serial_mode_q;
  logic [9:0]  serial_control_q;
  logic [10:0] fifo_control_q;
  logic [15:0] baud_div_q;
  logic [7:0]  status_q;
  logic        overrun_q;
  logic        overrun_seen_q;
  // fifos
  logic [7:0]  tx_mem [DEPTH];
  logic [7:0]  rx_mem [DEPTH];
  logic [3:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [4:0]  tx_cnt_q, rx_cnt_q;
  // synchronisers
  logic [2:0]  rxd_s_q, cts_s_q, sclk_s_q;
  // tick and shifters
  logic [15:0] baud_cnt_q;
  logic        tick;
  logic        sclk_gen_q;
  fsu_tx_state_type tx_st_q;
  fsu_rx_state_type rx_st_q;
  logic [3:0]  tx_os_q, rx_os_q;
  logic [7:0]  tx_shift_reg_q, rx_shift_reg_q;
  logic [2:0]  tx_bit_q, rx_bit_q;
  logic        tx_stop2_q, tx_par_q, rx_par_q, rx_fer_q, rx_per_q;
  logic [3:0]  brk_run_q;
  logic        rx_done;

  // apb decode
  logic wr_en, rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  logic is_async, par_en, seven, te, re, mce;
  assign is_async = ~serial_mode_q[`FSU_MODE_SYNC];
  assign par_en   = serial_mode_q[`FSU_MODE_PE];
  assign seven    = serial_mode_q[`FSU_MODE_CHR];
  assign te       = serial_control_q[`FSU_CTRL_TE];
  assign re       = serial_control_q[`FSU_CTRL_RE];
  assign mce      = fifo_control_q[`FSU_FC_MCE];
  logic [1:0] cke, ttrg_sel;
  assign cke      = serial_control_q[`FSU_CTRL_CLOCK_SOURCE_SEL_HIGH:`FSU_CTRL_CLOCK_SOURCE_SEL_LOW];
  assign ttrg_sel = fifo_control_q[`FSU_FC_TTRG_LO +: 2];
  logic [4:0] ttrg;
  // tx trigger levels: 8, 4, 2, 0
  always_comb
  begin
    case (ttrg_sel)
      2'd0:    ttrg = 5'd8;
      2'd1:    ttrg = 5'd4;
      2'd2:    ttrg = 5'd2;
      default: ttrg = 5'd0;
    endcase
  end
  logic tx_push, rx_pop, tx_pop, rx_push;
  assign tx_push = wr_en & (paddr == `FSU_ADDR_TXDATA) & (tx_cnt_q != 5'(DEPTH));
  assign rx_pop  = rd_en & (paddr == `FSU_ADDR_RXDATA) & (rx_cnt_q != 5'd0);

  // control registers; writes take effect at the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_mode_q    <= 8'h00;
      serial_control_q <= 10'h000;
      fifo_control_q   <= 11'h000;
      baud_div_q       <= `FSU_RST_BAUD;
    end
    else if (wr_en)
    begin
      case (paddr)
        `FSU_ADDR_MODE:    serial_mode_q    <= pwdata[7:0];
        `FSU_ADDR_CTRL:    serial_control_q <= pwdata[9:0];
        `FSU_ADDR_FIFOCTL: fifo_control_q   <= pwdata[10:0];
        `FSU_ADDR_BAUD:    baud_div_q       <= pwdata[15:0];
        default:           ;
      endcase
    end
  end

  // apb read path, zero wait state; unmapped reads zero with pslverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable)
      begin
        case (paddr)
          `FSU_ADDR_MODE:    prdata <= {24'h0, serial_mode_q};
          `FSU_ADDR_CTRL:    prdata <= {22'h0, serial_control_q};
          `FSU_ADDR_STATUS:  prdata <= {24'h0, status_q};
          `FSU_ADDR_FIFOCTL: prdata <= {21'h0, fifo_control_q};
          `FSU_ADDR_RXDATA:  prdata <= {24'h0, rx_mem[rx_rp_q]};
          `FSU_ADDR_COUNT:   prdata <= {19'h0, tx_cnt_q, 3'h0, rx_cnt_q};
          `FSU_ADDR_LINE:    prdata <= {31'h0, overrun_q};
          `FSU_ADDR_BAUD:    prdata <= {16'h0, baud_div_q};
          `FSU_ADDR_TXDATA:  prdata <= 32'h0000_0000;
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end
  // pready is registered one cycle after setup, so every access takes two cycles
  logic unused_ok;
  assign unused_ok = pready;

  // pin synchronisers; rxd used after three flops, cts_n and sclk_in after two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_s_q  <= 3'b111;
      cts_s_q  <= 3'b111;
      sclk_s_q <= 3'b000;
    end
    else
    begin
      rxd_s_q  <= {rxd_s_q[1:0], rxd};
      cts_s_q  <= {cts_s_q[1:0], cts_n};
      sclk_s_q <= {sclk_s_q[1:0], sclk_in};
    end
  end

  // 16x tick: baud counter or rising edge of external 16x clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_cnt_q <= 16'h0000;
      sclk_gen_q <= 1'b0;
    end
    else if (baud_cnt_q >= baud_div_q)
    begin
      baud_cnt_q <= 16'h0000;
      sclk_gen_q <= ~sclk_gen_q;
    end
    else
      baud_cnt_q <= baud_cnt_q + 16'h0001;
  end
  logic int_tick;
  assign int_tick = (baud_cnt_q >= baud_div_q) & sclk_gen_q;
  // external clock must keep running or the unit stalls
  assign tick = (is_async & cke == 2'b10) ? (sclk_s_q[1] & ~sclk_s_q[2]) : int_tick;

  // sclk pin role
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_out <= 1'b0;
      sclk_oe  <= 1'b0;
    end
    else if (is_async)
    begin
      case (cke)
        2'b00:
        begin
          sclk_oe  <= serial_control_q[`FSU_CTRL_SCLK_PORT_DIRECTION];
          sclk_out <= serial_control_q[`FSU_CTRL_SCLK_PORT_VALUE];
        end
        2'b01:
        begin
          sclk_oe  <= 1'b1;
          sclk_out <= sclk_gen_q;
        end
        default:
        begin
          sclk_oe  <= 1'b0; // input, or prohibited setting
          sclk_out <= 1'b0;
        end
      endcase
    end
    else
    begin
      sclk_oe  <= ~cke[1];
      sclk_out <= 1'b1;
    end
  end

  // transmit fifo; reset bit empties it, te clear leaves it alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp_q  <= 4'h0;
      tx_rp_q  <= 4'h0;
      tx_cnt_q <= 5'h00;
    end
    else if (fifo_control_q[`FSU_FC_TX_FIFO_RESET])
    begin
      tx_wp_q  <= 4'h0;
      tx_rp_q  <= 4'h0;
      tx_cnt_q <= 5'h00;
    end
    else
    begin
      if (tx_push)
        tx_wp_q <= tx_wp_q + 4'h1;
      if (tx_pop)
        tx_rp_q <= tx_rp_q + 4'h1;
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end
  always_ff @(posedge pclk)
  begin
    if (tx_push)
      tx_mem[tx_wp_q] <= pwdata[7:0];
  end

  // transmitter; cts gates only the start of a new frame
  logic tx_can_start;
  assign tx_can_start = te & (tx_cnt_q != 5'd0) & ~(mce & cts_s_q[1]);
  assign tx_pop = tick & (tx_os_q == 4'hF) & tx_can_start
                  & ((tx_st_q == TX_IDLE) | (tx_st_q == TX_STOP & ~tx_stop2_q));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q        <= TX_IDLE;
      tx_os_q        <= 4'h0;
      tx_bit_q       <= 3'h0;
      tx_shift_reg_q <= 8'h00;
      tx_stop2_q     <= 1'b0;
      tx_par_q       <= 1'b0;
      txd            <= 1'b1;
    end
    else if (!te)
    begin
      tx_st_q <= TX_IDLE;
      tx_os_q <= 4'h0;
      txd     <= 1'b1;
    end
    else if (tick)
    begin
      tx_os_q <= tx_os_q + 4'h1;
      if (tx_os_q == 4'hF)
      begin
        case (tx_st_q)
          TX_IDLE, TX_STOP:
          begin
            if (tx_st_q == TX_STOP & tx_stop2_q)
            begin
              tx_stop2_q <= 1'b0; // second stop bit
              txd        <= 1'b1;
            end
            else if (tx_pop)
            begin
              tx_shift_reg_q <= tx_mem[tx_rp_q];
              tx_par_q       <= serial_mode_q[`FSU_MODE_ODD];
              tx_st_q        <= TX_START;
              txd            <= 1'b0;
            end
            else
            begin
              tx_st_q <= TX_IDLE;
              txd     <= 1'b1;
            end
          end
          TX_START, TX_DATA:
          begin
            // last data bit ends: parity or first stop goes out next
            if (tx_st_q == TX_DATA & tx_bit_q == (seven ? 3'd6 : 3'd7))
            begin
              txd        <= par_en ? tx_par_q : 1'b1;
              tx_st_q    <= par_en ? TX_PAR : TX_STOP;
              tx_stop2_q <= par_en ? 1'b0 : serial_mode_q[`FSU_MODE_STOP];
            end
            else
            begin
              txd            <= tx_shift_reg_q[0];
              tx_par_q       <= tx_par_q ^ tx_shift_reg_q[0];
              tx_shift_reg_q <= {1'b0, tx_shift_reg_q[7:1]};
              tx_bit_q       <= (tx_st_q == TX_START) ? 3'h0 : tx_bit_q + 3'h1;
              tx_st_q        <= TX_DATA;
            end
          end
          TX_PAR:
          begin
            txd        <= 1'b1; // first stop after parity
            tx_st_q    <= TX_STOP;
            tx_stop2_q <= serial_mode_q[`FSU_MODE_STOP];
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end
  // stop bit output: data states without parity, and TX_PAR, fall to stop with line high
  logic tx_end_evt;
  assign tx_end_evt = tick & (tx_os_q == 4'hF) & (tx_st_q == TX_STOP) & ~tx_stop2_q & ~tx_pop;

  // receiver: start edge, then sample at mid bit
  logic rxs;
  assign rxs = rxd_s_q[2];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q        <= RX_IDLE;
      rx_os_q        <= 4'h0;
      rx_bit_q       <= 3'h0;
      rx_shift_reg_q <= 8'h00;
      rx_par_q       <= 1'b0;
      rx_per_q       <= 1'b0;
      rx_fer_q       <= 1'b0;
      brk_run_q      <= 4'h0;
    end
    else if (!re)
      rx_st_q <= RX_IDLE;
    else if (tick)
    begin
      rx_os_q <= rx_os_q + 4'h1;
      case (rx_st_q)
        RX_IDLE:
          if (!rxs)
          begin
            rx_st_q <= RX_START;
            rx_os_q <= 4'h0;
          end
        RX_START:
          if (rx_os_q == 4'(`FSU_OVS_MID))
          begin
            rx_os_q   <= 4'h0;
            rx_bit_q  <= 3'h0;
            rx_par_q  <= serial_mode_q[`FSU_MODE_ODD];
            brk_run_q <= 4'h1;
            rx_st_q   <= rxs ? RX_IDLE : RX_DATA; // glitch rejected
          end
        RX_DATA:
          if (rx_os_q == 4'hF)
          begin
            rx_shift_reg_q <= seven ? {1'b0, rxs, rx_shift_reg_q[6:1]}
                                    : {rxs, rx_shift_reg_q[7:1]};
            rx_par_q  <= rx_par_q ^ rxs;
            brk_run_q <= rxs ? 4'h0 : brk_run_q + 4'h1;
            rx_bit_q  <= rx_bit_q + 3'h1;
            if (rx_bit_q == (seven ? 3'd6 : 3'd7))
              rx_st_q <= par_en ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_os_q == 4'hF)
          begin
            rx_per_q  <= rx_par_q ^ rxs;
            brk_run_q <= rxs ? 4'h0 : brk_run_q + 4'h1;
            rx_st_q   <= RX_STOP;
          end
        RX_STOP:
          if (rx_os_q == 4'hF)
          begin
            rx_fer_q <= ~rxs; // only first stop checked
            rx_st_q  <= RX_IDLE;
          end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end
  assign rx_done = re & tick & (rx_st_q == RX_STOP) & (rx_os_q == 4'hF);
  logic rx_brk_now, rx_store;
  assign rx_brk_now = ~rxs & (brk_run_q >= `FSU_BRK_BITS - 4'd1);
  assign rx_store = rx_done & rxs & (rx_cnt_q != 5'(DEPTH)) & ~overrun_q
                    & ~status_q[`FSU_ST_BRK];
  assign rx_push = rx_store;

  // receive fifo
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp_q  <= 4'h0;
      rx_rp_q  <= 4'h0;
      rx_cnt_q <= 5'h00;
    end
    else if (fifo_control_q[`FSU_FC_RFRST])
    begin
      rx_wp_q  <= 4'h0;
      rx_rp_q  <= 4'h0;
      rx_cnt_q <= 5'h00;
    end
    else
    begin
      if (rx_push)
        rx_wp_q <= rx_wp_q + 4'h1;
      if (rx_pop)
        rx_rp_q <= rx_rp_q + 4'h1;
      rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end
  always_ff @(posedge pclk)
  begin
    if (rx_push)
      rx_mem[rx_wp_q] <= rx_shift_reg_q;
  end

  // status flags; hardware set wins over a software clear of 0
  logic st_wr;
  assign st_wr = wr_en & (paddr == `FSU_ADDR_STATUS);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= `FSU_RST_STATUS;
    else
    begin
      if (st_wr)
        status_q <= status_q & pwdata[7:0];
      status_q[`FSU_ST_TX_FIFO_LOW_FLAG] <= (tx_cnt_q <= ttrg)
                                | (status_q[`FSU_ST_TX_FIFO_LOW_FLAG] & ~(st_wr & ~pwdata[`FSU_ST_TX_FIFO_LOW_FLAG]));
      if (tx_cnt_q < ttrg)
        status_q[`FSU_ST_TX_FIFO_LOW_FLAG] <= 1'b1;
      if (tx_end_evt)
        status_q[`FSU_ST_TX_END_FLAG] <= 1'b1;
      else if (tx_pop)
        status_q[`FSU_ST_TX_END_FLAG] <= 1'b0;
      status_q[`FSU_ST_RDF] <= (rx_cnt_q >= 5'd1) & (status_q[`FSU_ST_RDF] | rx_push);
      status_q[`FSU_ST_DR]  <= (rx_cnt_q != 5'd0) & status_q[`FSU_ST_DR] & ~st_wr;
      if (rx_push)
        status_q[`FSU_ST_RDF] <= 1'b1;
      if (rx_done & rx_per_q & par_en)
        status_q[`FSU_ST_PER] <= 1'b1;
      if (rx_done & ~rxs)
        status_q[`FSU_ST_FER] <= 1'b1;
      if (rx_done & ((rx_per_q & par_en) | ~rxs))
        status_q[`FSU_ST_ER] <= 1'b1;
      if (rx_done & rx_brk_now)
        status_q[`FSU_ST_BRK] <= 1'b1;
    end
  end

  // overrun: set on full, cleared by writing 0 only after reading 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overrun_q      <= 1'b0;
      overrun_seen_q <= 1'b0;
    end
    else if (rx_done & rxs & (rx_cnt_q == 5'(DEPTH)))
    begin
      overrun_q <= 1'b1;
    end
    else
    begin
      if (rd_en & (paddr == `FSU_ADDR_LINE) & overrun_q)
        overrun_seen_q <= 1'b1;
      if (wr_en & (paddr == `FSU_ADDR_LINE) & ~pwdata[0] & overrun_seen_q)
      begin
        overrun_q      <= 1'b0;
        overrun_seen_q <= 1'b0;
      end
    end
  end

  // interrupt and rts outputs, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_fifo_irq  <= 1'b0;
      rx_data_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      break_irq    <= 1'b0;
      rts_n        <= 1'b1;
    end
    else
    begin
      tx_fifo_irq  <= status_q[`FSU_ST_TX_FIFO_LOW_FLAG] & serial_control_q[`FSU_CTRL_TIE];
      rx_data_irq  <= (status_q[`FSU_ST_RDF] | status_q[`FSU_ST_DR])
                      & serial_control_q[`FSU_CTRL_RIE];
      rx_error_irq <= status_q[`FSU_ST_ER]
                      & (serial_control_q[`FSU_CTRL_RIE] | serial_control_q[`FSU_CTRL_RX_ERROR_IRQ_ENABLE]);
      break_irq    <= (status_q[`FSU_ST_BRK] | overrun_q)
                      & (serial_control_q[`FSU_CTRL_RIE] | serial_control_q[`FSU_CTRL_RX_ERROR_IRQ_ENABLE]);
      rts_n        <= mce ? (rx_cnt_q == 5'(DEPTH)) : 1'b1;
    end
  end

  // overrun must follow a completed char into a full fifo within one cycle
  chk_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done & rxs & (rx_cnt_q == 5'(DEPTH)) |=> overrun_q)
    else $error("overrun not set");
  chk_full_no_store: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_cnt_q == 5'(DEPTH)) |-> !rx_push)
    else $error("store into full fifo");
  chk_te_mark: assert property (@(posedge pclk) disable iff (!presetn)
    !te |=> txd)
    else $error("line not at mark");
  chk_rts_full: assert property (@(posedge pclk) disable iff (!presetn)
    mce & (rx_cnt_q == 5'(DEPTH)) ##1 mce |-> rts_n)
    else $error("rts low with full fifo");
  chk_cts_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mce & cts_s_q[1] |-> !tx_pop)
    else $error("frame started under cts");
  chk_tx_fifo_low_flag_low: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_cnt_q < ttrg) |=> status_q[`FSU_ST_TX_FIFO_LOW_FLAG])
    else $error("tx low flag missing");
  chk_tx_end_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    tx_end_evt |=> status_q[`FSU_ST_TX_END_FLAG] && txd)
    else $error("end flag missing");
  chk_start_low: assert property (@(posedge pclk) disable iff (!presetn)
    tx_pop |=> !txd && (tx_st_q == TX_START))
    else $error("start bit not low");
  chk_te_keeps_fifo: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(te) & !fifo_control_q[`FSU_FC_TX_FIFO_RESET] |=> (tx_cnt_q == $past(tx_cnt_q)))
    else $error("fifo changed on te clear");
  chk_rx_err_irq: assert property (@(posedge pclk) disable iff (!presetn)
    status_q[`FSU_ST_ER] & serial_control_q[`FSU_CTRL_RX_ERROR_IRQ_ENABLE] |=> rx_error_irq)
    else $error("error irq missing");
endmodule : fsu_top
`default_nettype wire

//--- hdl/fsu_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the serial unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef FSU_CFG_SVH
`define FSU_CFG_SVH
`define FSU_ADDR_MODE      8'h00
`define FSU_ADDR_CTRL      8'h04
`define FSU_ADDR_STATUS    8'h08
`define FSU_ADDR_FIFOCTL   8'h0C
`define FSU_ADDR_TXDATA    8'h10
`define FSU_ADDR_RXDATA    8'h14
`define FSU_ADDR_COUNT     8'h18
`define FSU_ADDR_LINE      8'h1C
`define FSU_ADDR_BAUD      8'h20
// mode register fields
`define FSU_MODE_STOP      3
`define FSU_MODE_ODD       4
`define FSU_MODE_PE        5
`define FSU_MODE_CHR       6
`define FSU_MODE_SYNC      7
// control register fields
`define FSU_CTRL_CLOCK_SOURCE_SEL_LOW      0
`define FSU_CTRL_CLOCK_SOURCE_SEL_HIGH      1
`define FSU_CTRL_RX_ERROR_IRQ_ENABLE      3
`define FSU_CTRL_RE        4
`define FSU_CTRL_TE        5
`define FSU_CTRL_RIE       6
`define FSU_CTRL_TIE       7
`define FSU_CTRL_SCLK_PORT_DIRECTION     8
`define FSU_CTRL_SCLK_PORT_VALUE     9
// status register fields
`define FSU_ST_DR          0
`define FSU_ST_RDF         1
`define FSU_ST_PER         2
`define FSU_ST_FER         3
`define FSU_ST_BRK         4
`define FSU_ST_TX_FIFO_LOW_FLAG        5
`define FSU_ST_TX_END_FLAG        6
`define FSU_ST_ER          7
// fifo control fields
`define FSU_FC_RFRST       0
`define FSU_FC_TX_FIFO_RESET       1
`define FSU_FC_MCE         3
`define FSU_FC_TTRG_LO     4
`define FSU_FC_RTRG_LO     8
// reset values
`define FSU_RST_STATUS     8'h60
`define FSU_RST_BAUD       16'h0000
// fifo geometry and oversampling
`define FSU_FIFO_DEPTH     16
`define FSU_OVS            16
`define FSU_OVS_MID        7
`define FSU_BRK_BITS       4'h9
`endif

//--- hdl/fsu_pkg.sv
// Purpose: types shared by the serial unit
// Assumes: nothing beyond the cfg header
// Notes: state enums only
package fsu_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fsu_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fsu_rx_state_type;
endpackage : fsu_pkg

//--- bench/fsu_remote.sv
// Purpose: remote serial device facing the fifo serial unit
// Assumes: 8 data bits, no parity, one stop; BIT pclk cycles per bit
// Notes: behavioural; catches every frame on txd into got
`timescale 1ns/100ps
`default_nettype none
module fsu_remote #(parameter int BIT = 32)
(
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n
);
  logic [7:0] got[$];
  // idle line at mark, handshake open
  initial
  begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  // one frame: low start, data lsb first, high stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask : send
  // sample at bit centres, from the start edge
  always
  begin : catch_tx
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge pclk);
      b[i] = txd;
    end
    repeat (BIT) @(posedge pclk);
    got.push_back(b);
  end
endmodule : fsu_remote
`default_nettype wire

//--- bench/test_fifo_uart_async_mode.sv
// Purpose: self-checking bench of the fifo serial unit
// Assumes: baud 0, so 32 pclk per bit
// Notes: expected bytes kept in queues
`timescale 1ns/100ps
`default_nettype none
`include "fsu_cfg.svh"
module test_fifo_uart_async_mode;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        txd, rxd, cts_n, rts_n, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  q[$];
  int          fail_count, checked, n;
  fsu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n),
    .sclk_in(1'b0), .sclk_out(), .sclk_oe(), .tx_fifo_irq(), .rx_data_irq(),
    .rx_error_irq(), .break_irq());
  fsu_remote #(.BIT(32)) i_remote (.pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // watchdog well beyond the longest expected run
  initial
  begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    conclude();
  end
  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    void'($urandom(98472));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FSU_ADDR_STATUS, 0);
    check("status reset", r[7:0], `FSU_RST_STATUS);
    apb(1'b0, 8'h24, 0);
    check("unmapped err", e, 1'b1);
    // format set while both enables are still off
    apb(1'b1, `FSU_ADDR_BAUD, 0);
    apb(1'b1, `FSU_ADDR_MODE, 0);
    apb(1'b1, `FSU_ADDR_FIFOCTL, 32'h0000_0008);
    apb(1'b1, `FSU_ADDR_CTRL, 32'h0000_0030);
    // four frames back to back; 4 is within 16 minus trigger 8
    for (int i = 0; i < 4; i++)
    begin
      q.push_back(8'($urandom));
      apb(1'b1, `FSU_ADDR_TXDATA, {24'h0, q[i]});
    end
    n = 0;
    while (i_remote.got.size() < 4 && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
    for (int i = 0; i < 4; i++)
      check("tx byte", i_remote.got[i], q[i]);
    // remote takes the byte at mid stop; end flag rises at stop end
    repeat (40) @(posedge pclk);
    apb(1'b0, `FSU_ADDR_STATUS, 0);
    check("tx end", r[`FSU_ST_TX_END_FLAG], 1'b1);
    // fill the receive fifo to 16, then overrun
    q.delete();
    for (int i = 0; i < 17; i++)
    begin
      q.push_back(8'($urandom));
      i_remote.send(q[i]);
    end
    repeat (40) @(posedge pclk);
    check("rts full", rts_n, 1'b1);
    apb(1'b0, `FSU_ADDR_COUNT, 0);
    check("rx count", r[4:0], 5'h10);
    apb(1'b0, `FSU_ADDR_LINE, 0);
    check("overrun", r[0], 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, `FSU_ADDR_RXDATA, 0);
      check("rx byte", r[7:0], q[i]);
    end
    // pop lands at the access edge, rts follows one edge later
    repeat (3) @(posedge pclk);
    check("rts open", rts_n, 1'b0);
    conclude();
  end
endmodule : test_fifo_uart_async_mode
`default_nettype wire
